//--- hdl/dpvu_pkg.sv
package dpvu_pkg;

    // ========================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_UNIT  = 8'h04;
    localparam logic [7:0] ADDR_SIZE  = 8'h08;
    localparam logic [7:0] ADDR_STAT  = 8'h0C;
    localparam logic [7:0] ADDR_MASK  = 8'h10;
    localparam logic [7:0] ADDR_VEL   = 8'h14;
    localparam logic [7:0] ADDR_CLUT  = 8'h18;
    localparam logic [7:0] ADDR_PSTAT = 8'h1C;

    // ========================================
    // field positions
    localparam int CTRL_EN    = 0;
    localparam int CTRL_MODE  = 1;
    localparam int CTRL_RATIO = 3;
    localparam int CTRL_FILT  = 5;
    localparam int SIZE_N     = 0;
    localparam int SIZE_K     = 8;
    localparam int ST_RAY     = 0;
    localparam int ST_BAD     = 1;
    localparam int ST_HOST    = 2;
    localparam int ST_W       = 3;

    // ========================================
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [15:0] UNIT_RST = 16'h0064;
    localparam logic [15:0] SIZE_RST = 16'h0420;

    // ========================================
    // angle scale: 16'h8000 is pi
    localparam logic signed [15:0] ANG_PI   = 16'sh8000;
    localparam logic signed [15:0] ANG_2PI3 = 16'sh5555;
    localparam logic signed [15:0] ANG_PI2  = 16'sh4000;
    localparam logic signed [17:0] DIV3     = 18'sh05556;
    localparam logic [15:0]        WS_23    = 16'hAAAB;
    localparam logic [15:0]        WS_34    = 16'hC000;
    localparam logic [15:0]        WS_45    = 16'hCCCD;

    typedef enum logic [1:0] {
        MODE_SHORT,
        MODE_PERRAY,
        MODE_ALT
    } dpvu_mode_t;

    typedef enum logic [1:0] {
        RATIO_32,
        RATIO_43,
        RATIO_54
    } dpvu_ratio_t;

    typedef struct packed {
        logic signed [15:0] thetaHigh;
        logic signed [15:0] thetaLow;
        logic [15:0]        widthHigh;
        logic [15:0]        widthLow;
    } dpvu_moment_t;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } dpvu_iq_t;

    typedef struct packed {
        logic signed [15:0] velocity;
        logic [15:0]        width;
        logic [31:0]        clutter;
        logic               velRef;
        logic               lowRate;
    } dpvu_ray_t;

endpackage

//--- hdl/dpvu_unfolder.sv
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
module dpvu_unfolder
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  iqValid,
    input  wire dpvu_pkg::dpvu_iq_t    iqIn,
    input  wire logic                  momentValid,
    input  wire dpvu_pkg::dpvu_moment_t momentIn,
    output logic                       trigOut,
    output logic                       trigLow,
    output logic                       rayValid,
    output dpvu_pkg::dpvu_ray_t        rayOut,
    output logic                       irq
);
    import dpvu_pkg::*;

    typedef struct packed {
        logic [31:0]        ctrl;
        logic [15:0]        unit;
        logic [15:0]        size;
        logic [ST_W-1:0]    stat;
        logic [ST_W-1:0]    mask;
        logic [31:0]        rdata;
        logic               slverr;
        logic [19:0]        perCnt;
        logic [8:0]         pulseCnt;
        logic               rate;
        logic               phase;
        logic               rayRate;
        logic               trig;
        logic               trigLow;
        logic               prevHOk;
        logic               prevLOk;
        logic signed [15:0] prevH;
        logic signed [15:0] prevL;
        logic signed [23:0] sumI;
        logic signed [23:0] sumQ;
        logic               rayValid;
        dpvu_ray_t          ray;
    } dpvu_state_t;

    dpvu_state_t s;
    dpvu_state_t next_s;

    // ========================================
    // fold selection over the unfolded plane
    function automatic logic signed [15:0] unfold(
        input logic signed [15:0] th,
        input logic signed [15:0] phi,
        input logic [2:0]         m
    );
        logic signed [15:0] base;
        logic signed [15:0] step;
        logic signed [15:0] cand;
        logic signed [15:0] best;
        logic signed [15:0] d;
        logic [15:0]        ad;
        logic [15:0]        bestD;
        logic signed [33:0] prod;
        prod = th * DIV3;
        case (m)
            3'd2:
            begin
                base = th >>> 1;
                step = ANG_PI;
            end
            3'd3:
            begin
                base = prod[31:16];
                step = ANG_2PI3;
            end
            default:
            begin
                base = th >>> 2;
                step = ANG_PI2;
            end
        endcase
        cand = base;
        best = base;
        bestD = 16'hFFFF;
        for (int j = 0; j < 4; j++)
        begin
            // wrap on 16 bits keeps distances circular
            d = cand - phi;
            ad = d[15] ? 16'(-d) : 16'(d);
            if ((j < int'(m)) && (ad < bestD))
            begin
                best = cand;
                bestD = ad;
            end
            cand = cand + step;
        end
        return best;
    endfunction

    // low-rate width onto the high-rate scale
    function automatic logic [15:0] wscale(
        input logic [15:0] w,
        input dpvu_ratio_t r
    );
        logic [31:0] p;
        p = 32'h00000000;
        case (r)
            RATIO_32: p = w * WS_23;
            RATIO_43: p = w * WS_34;
            default:  p = w * WS_45;
        endcase
        return p[31:16];
    endfunction

    // ========================================
    // combinational decode of the current state
    dpvu_mode_t         mode;
    dpvu_ratio_t        ratio;
    logic               en;
    logic               cfgBad;
    logic               hostUnfold;
    logic [2:0]         mH;
    logic [2:0]         mL;
    logic [2:0]         num;
    logic [18:0]        lowP;
    logic [18:0]        highP;
    logic [18:0]        perSel;
    logic [8:0]         blockLen;
    logic               wr;
    logic               setup;
    logic               mapped;
    logic [ST_W-1:0]    evt;
    logic signed [15:0] phi;
    logic signed [15:0] vH;
    logic signed [15:0] vL;
    logic signed [15:0] vDiff;
    logic signed [15:0] thLA;
    logic signed [15:0] thHA;
    logic signed [15:0] phiA;
    logic signed [15:0] vA;
    logic [16:0]        wSum;
    logic [48:0]        pwr;

    always_comb
    begin
        mode = dpvu_mode_t'(s.ctrl[CTRL_MODE+:2]);
        ratio = dpvu_ratio_t'(s.ctrl[CTRL_RATIO+:2]);
        en = s.ctrl[CTRL_EN];
        hostUnfold = (ratio != RATIO_32) && (ratio != RATIO_43);
        mH = (ratio == RATIO_32) ? 3'd2 : 3'd3;
        mL = mH + 3'd1;
        num = 3'd3 + {1'b0, s.ctrl[CTRL_RATIO+:2]};
        lowP = 19'(s.unit) * 19'(num);
        highP = 19'(s.unit) * 19'(num - 3'd1);
        blockLen = 9'(s.size[SIZE_N+:8]) + 9'(s.size[SIZE_K+:8]);
        // odd N, zero unit or illegal codes stop the trigger
        cfgBad = s.size[SIZE_N] || (s.unit == 16'h0000)
            || (s.ctrl[CTRL_MODE+:2] == 2'd3)
            || (s.ctrl[CTRL_RATIO+:2] == 2'd3);
        wr = psel && penable && pwrite;
        setup = psel && !penable;
    end

    // per-ray unfolding from the ray's own two angles
    always_comb
    begin
        phi = momentIn.thetaLow - momentIn.thetaHigh;
        vH = unfold(momentIn.thetaHigh, phi, mH);
        vL = unfold(momentIn.thetaLow, phi, mL);
        vDiff = vL - vH;
        wSum = 17'(momentIn.widthHigh)
            + 17'(wscale(momentIn.widthLow, ratio));
        // alternating: pair this block with the stored one
        thLA = s.rayRate ? momentIn.thetaLow : s.prevL;
        thHA = s.rayRate ? s.prevH : momentIn.thetaHigh;
        phiA = thLA - thHA;
        vA = s.rayRate ? unfold(thLA, phiA, mL)
                       : unfold(thHA, phiA, mH);
        // widen before squaring so large DC sums keep their top bits
        pwr = 49'(s.sumI) * 49'(s.sumI)
            + 49'(s.sumQ) * 49'(s.sumQ);
    end

    // ========================================
    // next-state logic
    always_comb
    begin
        next_s = s;
        next_s.trig = 1'b0;
        next_s.rayValid = 1'b0;
        evt = '0;
        mapped = 1'b1;
        perSel = highP;
        if (cfgBad && en)
        begin
            evt[ST_BAD] = 1'b1;
        end

        // register read decode, captured in setup
        next_s.rdata = 32'h00000000;
        case (8'(paddr))
            ADDR_CTRL:  next_s.rdata = s.ctrl;
            ADDR_UNIT:  next_s.rdata = {16'h0000, s.unit};
            ADDR_SIZE:  next_s.rdata = {16'h0000, s.size};
            ADDR_STAT:  next_s.rdata = 32'(s.stat);
            ADDR_MASK:  next_s.rdata = 32'(s.mask);
            ADDR_VEL:   next_s.rdata = {s.ray.width, s.ray.velocity};
            ADDR_CLUT:  next_s.rdata = s.ray.clutter;
            ADDR_PSTAT: next_s.rdata = {28'h0000000, s.rate,
                            s.prevHOk && s.prevLOk, hostUnfold,
                            cfgBad};
            default:    mapped = 1'b0;
        endcase
        if (setup)
        begin
            next_s.slverr = !mapped;
        end
        else
        begin
            next_s.rdata = s.rdata;
        end

        // register writes in the access cycle
        if (wr && !s.slverr)
        begin
            case (8'(paddr))
                ADDR_CTRL:
                begin
                    next_s.ctrl = pwdata;
                    if (pwdata[CTRL_MODE+:4] != s.ctrl[CTRL_MODE+:4])
                    begin
                        next_s.prevHOk = 1'b0;
                        next_s.prevLOk = 1'b0;
                        next_s.pulseCnt = 9'h000;
                        next_s.rate = 1'b0;
                        next_s.phase = 1'b0;
                    end
                end
                ADDR_UNIT: next_s.unit = pwdata[15:0];
                ADDR_SIZE: next_s.size = pwdata[15:0];
                ADDR_MASK: next_s.mask = pwdata[ST_W-1:0];
                default:;
            endcase
        end

        // trigger generator
        if (!en || cfgBad)
        begin
            next_s.perCnt = 20'h00000;
        end
        else if (s.perCnt == 20'h00000)
        begin
            unique case (mode)
                MODE_PERRAY: next_s.trigLow = s.phase;
                MODE_ALT:    next_s.trigLow = s.rate;
                default:     next_s.trigLow = 1'b0;
            endcase
            perSel = next_s.trigLow ? lowP : highP;
            next_s.trig = 1'b1;
            next_s.perCnt = 20'(perSel) - 20'h00001;
            next_s.phase = !s.phase;
            if (mode == MODE_ALT)
            begin
                // a block ends after its N+k-th pulse
                if (s.pulseCnt >= blockLen - 9'h001)
                begin
                    next_s.pulseCnt = 9'h000;
                    next_s.rayRate = s.rate;
                    next_s.rate = !s.rate;
                end
                else
                begin
                    next_s.pulseCnt = s.pulseCnt + 9'h001;
                end
            end
        end
        else
        begin
            next_s.perCnt = s.perCnt - 20'h00001;
        end

        // DC sums for the clutter estimate
        if (iqValid)
        begin
            next_s.sumI = s.sumI + 24'(iqIn.i);
            next_s.sumQ = s.sumQ + 24'(iqIn.q);
        end

        // one output ray per moment set
        if (momentValid && en && !cfgBad)
        begin
            next_s.rayValid = 1'b1;
            evt[ST_RAY] = 1'b1;
            evt[ST_HOST] = hostUnfold;
            next_s.ray.clutter = (s.ctrl[CTRL_FILT+:3] != 3'h0)
                ? pwr[48:17] : 32'h00000000;
            next_s.sumI = iqValid ? 24'(iqIn.i) : 24'sh000000;
            next_s.sumQ = iqValid ? 24'(iqIn.q) : 24'sh000000;
            next_s.ray.velRef = 1'b0;
            next_s.ray.lowRate = 1'b0;
            unique case (mode)
                MODE_PERRAY:
                begin
                    next_s.ray.width = wSum[16:1];
                    if (hostUnfold)
                    begin
                        next_s.ray.velocity = momentIn.thetaHigh;
                    end
                    else
                    begin
                        // halfway along the short arc
                        next_s.ray.velocity = vH + (vDiff >>> 1);
                        next_s.ray.velRef = 1'b1;
                    end
                end
                MODE_ALT:
                begin
                    next_s.ray.lowRate = s.rayRate;
                    if (s.rayRate)
                    begin
                        next_s.prevL = momentIn.thetaLow;
                        next_s.prevLOk = 1'b1;
                        next_s.ray.width = wscale(momentIn.widthLow,
                                                  ratio);
                    end
                    else
                    begin
                        next_s.prevH = momentIn.thetaHigh;
                        next_s.prevHOk = 1'b1;
                        next_s.ray.width = momentIn.widthHigh;
                    end
                    if (hostUnfold)
                    begin
                        next_s.ray.velocity = s.rayRate
                            ? momentIn.thetaLow : momentIn.thetaHigh;
                    end
                    else
                    begin
                        // plus and minus pi span the widened interval
                        next_s.ray.velocity = vA;
                        next_s.ray.velRef = s.rayRate
                            ? s.prevHOk : s.prevLOk;
                    end
                end
                default:
                begin
                    next_s.ray.velocity = momentIn.thetaHigh;
                    next_s.ray.width = momentIn.widthHigh;
                end
            endcase
        end

        // sticky status: a new event beats a same-cycle clear
        next_s.stat = s.stat & ~((wr && (8'(paddr) == ADDR_STAT))
            ? pwdata[ST_W-1:0] : {ST_W{1'b0}});
        next_s.stat = next_s.stat | evt;
    end

    // ========================================
    // state register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.unit <= UNIT_RST;
            s.size <= SIZE_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs from the state, pready tied high, pslverr gated by psel and penable
    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = s.slverr && psel && penable;
    assign trigOut = s.trig;
    assign trigLow = s.trigLow;
    assign rayValid = s.rayValid;
    assign rayOut = s.ray;
    assign irq = |(s.stat & s.mask); // level, unmasked sticky bit

endmodule // dpvu_unfolder

//--- testbench/dpvu_checker.sv
`timescale 1ns/1ns
module dpvu_checker
(
    input wire logic                clk_sys,
    input wire logic                sys_rst,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                momentValid,
    input wire logic                trigOut,
    input wire logic                trigLow,
    input wire logic                rayValid,
    input wire dpvu_pkg::dpvu_ray_t rayOut,
    input wire logic                irq
);
    import dpvu_pkg::*;
    // =====
    // port checks, one clock domain
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_trig_pulse:
    assert property (trigOut |=> !trigOut)
        else $error("trigger wider than one cycle");
    // the reset edge itself may move the type, hence the past guard
    a_trig_type:
    assert property ($changed(trigLow) && !$past(sys_rst) |-> trigOut)
        else $error("trigger type moved without a trigger");
    a_ray_cause:
    assert property (rayValid |-> $past(momentValid))
        else $error("ray without a moment");
    a_ray_hold:
    assert property (!rayValid && !$past(sys_rst) |-> $stable(rayOut))
        else $error("ray data moved between rays");
    a_reset_quiet:
    assert property (@(posedge clk_sys) disable iff (1'b0)
        sys_rst |=> !rayValid && !trigOut && !irq)
        else $error("outputs active after reset");
    a_ready_high:
    assert property (pready)
        else $error("slave inserted a wait state");
    a_err_phase:
    assert property (pslverr |-> psel && penable)
        else $error("error outside the access phase");
    a_err_nodata:
    assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
endmodule // dpvu_checker

bind dpvu_unfolder dpvu_checker chk (
    .clk_sys, .sys_rst, .psel, .penable, .prdata, .pready, .pslverr,
    .momentValid, .trigOut, .trigLow, .rayValid, .rayOut, .irq
);

//--- testbench/dpvu_peer.sv
`timescale 1ns/1ns
module dpvu_peer
(
    input  wire logic              clk_sys,
    output logic                   iqValid,
    output dpvu_pkg::dpvu_iq_t     iqIn,
    output logic                   momentValid,
    output dpvu_pkg::dpvu_moment_t momentIn
);
    import dpvu_pkg::*;
    // =====
    // host side of the sample and moment streams
    initial
    begin
        iqValid = 1'b0;
        momentValid = 1'b0;
        iqIn = '0;
        momentIn = '0;
    end

    // idle lines show the inverse of the last value, so stale use shows
    task automatic sendIq(input dpvu_iq_t s);
        iqValid <= 1'b1;
        iqIn <= s;
        @(posedge clk_sys);
        iqValid <= 1'b0;
        iqIn <= ~s;
        @(posedge clk_sys);
    endtask

    // both angles travel so the host can unfold other ratios itself
    task automatic sendMoment(input dpvu_moment_t m);
        momentValid <= 1'b1;
        momentIn <= m;
        @(posedge clk_sys);
        momentValid <= 1'b0;
        momentIn <= ~m;
    endtask
endmodule // dpvu_peer

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); \
        end \
    end

module tb_top;
    import dpvu_pkg::*;
    logic         clk_sys;
    logic         sys_rst;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         iqValid;
    dpvu_iq_t     iqIn;
    logic         momentValid;
    dpvu_moment_t momentIn;
    logic         trigOut;
    logic         trigLow;
    logic         rayValid;
    dpvu_ray_t    rayOut;
    logic         irq;
    int           checks = 0;
    int           mismatches = 0;
    logic [31:0]  rd;
    logic         er;
    logic         irqSeen;
    dpvu_ray_t    ray;
    dpvu_moment_t mo;
    logic [31:0]  rstv [5] = '{CTRL_RST, 32'(UNIT_RST), 32'(SIZE_RST),
                               32'h0, 32'h0};

    dpvu_unfolder dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .iqValid, .iqIn,
        .momentValid, .momentIn, .trigOut, .trigLow, .rayValid, .rayOut,
        .irq);
    dpvu_peer peer (.clk_sys, .iqValid, .iqIn, .momentValid, .momentIn);

    // =====
    // clock and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // whole run needs a few hundred cycles; the 50000-cycle limit is far above that
    initial
    begin
        #200000;
        mismatches++;
        give_verdict();
    end

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // =====
    // bus, stream and reference helpers
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // ray shows one cycle after the moment; sampled mid-cycle
    task automatic mom(input dpvu_moment_t m);
        peer.sendMoment(m);
        @(negedge clk_sys);
        `CHK(rayValid, 1'b1)
        ray = rayOut;
        irqSeen = irq;
        @(posedge clk_sys);
    endtask

    task automatic waitTrig(output int gap);
        gap = 0;
        do
        begin
            @(negedge clk_sys);
            gap++;
        end
        while (trigOut !== 1'b1);
    endtask

    // nearest fold candidate to phi, ties keep the first
    function automatic logic signed [15:0] unf(
        input logic signed [15:0] th, input logic signed [15:0] phi,
        input int m);
        logic signed [31:0] p;
        logic signed [15:0] b;
        logic signed [15:0] c;
        logic signed [15:0] d;
        logic [15:0]        st;
        logic [15:0]        a;
        logic [15:0]        bd;
        p = th * 32'sh5556;
        b = th >>> (m / 2);
        if (m == 3)
            b = p[31:16];
        st = (m == 2) ? 16'h8000 : (m == 3) ? 16'h5555 : 16'h4000;
        bd = 16'hFFFF;
        unf = b;
        for (int j = 0; j < m; j++)
        begin
            c = b + 16'(j * st);
            d = c - phi;
            a = d[15] ? 16'(-d) : d;
            if (a < bd)
            begin
                bd = a;
                unf = c;
            end
        end
    endfunction

    function automatic logic [15:0] ws(input logic [15:0] w,
                                       input logic [15:0] k);
        logic [31:0] p;
        p = w * k;
        return p[31:16];
    endfunction

    // =====
    // main sequence
    initial
    begin
        int                 g;
        logic signed [15:0] vh;
        logic signed [15:0] vl;
        logic signed [15:0] df;
        logic signed [63:0] si;
        logic signed [63:0] sq;
        logic [63:0]        pw;
        logic [16:0]        w;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rd, rstv[i])
        end
        apb(1'b0, 8'h20, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, ADDR_VEL, 32'hFFFFFFFF);
        apb(1'b0, ADDR_VEL, 32'h0);
        `CHK(rd, 32'h0)
        // odd sample size must stop the trigger train
        apb(1'b1, ADDR_UNIT, 32'h1);
        apb(1'b1, ADDR_SIZE, 32'h0121);
        apb(1'b1, ADDR_CTRL, 32'h03);
        apb(1'b0, ADDR_PSTAT, 32'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[ST_BAD], 1'b1)
        repeat (8)
        begin
            @(negedge clk_sys);
            `CHK(trigOut, 1'b0)
        end
        @(posedge clk_sys);
        apb(1'b1, ADDR_SIZE, 32'h0102);
        apb(1'b1, ADDR_STAT, 32'hF);
        // per-ray mode at 3:2 and 4:3 with the filter on
        for (int r = 0; r < 2; r++)
        begin
            apb(1'b1, ADDR_CTRL, 32'h23 | (r << CTRL_RATIO));
            for (int t = 0; t < 5; t++)
            begin
                waitTrig(g);
                if (t > 0)
                    `CHK(g, trigLow ? r + 2 : r + 3)
            end
            @(posedge clk_sys);
            mo.thetaHigh = 16'(16'sh2E00 * (r + 2));
            mo.thetaLow = 16'(16'sh2E00 * (r + 3));
            mo.widthHigh = 16'h0300;
            mo.widthLow = 16'h0480;
            mom(mo);
            si = 64'sh0;
            sq = 64'sh0;
            for (int k = 1; k < 5; k++)
            begin
                peer.sendIq({16'(k * 16'h0300), 16'hFEDD});
                si = si + k * 64'sh300;
                sq = sq - 64'sh123;
            end
            mom(mo);
            df = mo.thetaLow - mo.thetaHigh;
            vh = unf(mo.thetaHigh, df, r + 2);
            vl = unf(mo.thetaLow, df, r + 3);
            df = vl - vh;
            `CHK(ray.velocity, 16'(vh + (df >>> 1)))
            `CHK(ray.velRef, 1'b1)
            w = mo.widthHigh + ws(mo.widthLow, r ? WS_34 : WS_23);
            `CHK(ray.width, w[16:1])
            pw = si * si + sq * sq;
            `CHK(ray.clutter, pw[48:17])
            apb(1'b0, ADDR_CLUT, 32'h0);
            `CHK(rd, pw[48:17])
        end
        // 5:4 leaves unfolding to the host, filter off
        apb(1'b1, ADDR_CTRL, 32'h13);
        peer.sendIq(32'h7FFF7FFF);
        mom(mo);
        `CHK(ray.clutter, 32'h0)
        `CHK(ray.velRef, 1'b0)
        apb(1'b0, ADDR_PSTAT, 32'h0);
        `CHK(rd[1], 1'b1)
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[ST_HOST], 1'b1)
        // interrupt raised, cleared, then masked
        apb(1'b1, ADDR_MASK, 32'h1);
        apb(1'b1, ADDR_STAT, 32'hF);
        mom(mo);
        `CHK(irqSeen, 1'b1)
        apb(1'b1, ADDR_STAT, 32'h1);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        @(posedge clk_sys);
        apb(1'b1, ADDR_MASK, 32'h0);
        mom(mo);
        `CHK(irqSeen, 1'b0)
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[ST_RAY], 1'b1)
        // alternating blocks of three at 3:2
        apb(1'b1, ADDR_CTRL, 32'h05);
        for (int t = 0; t < 5; t++)
        begin
            waitTrig(g);
            `CHK(trigLow, t > 2)
            if (t > 0)
                `CHK(g, t > 3 ? 3 : 2)
        end
        @(posedge clk_sys);
        mom(mo);
        `CHK(ray.lowRate, 1'b0)
        `CHK(ray.velRef, 1'b0)
        waitTrig(g);
        @(posedge clk_sys);
        mom(mo);
        `CHK(ray.lowRate, 1'b1)
        `CHK(ray.velRef, 1'b1)
        df = mo.thetaLow - mo.thetaHigh;
        `CHK(ray.velocity, unf(mo.thetaLow, df, 3))
        `CHK(ray.width, ws(mo.widthLow, WS_23))
        // both references held, high block running at the read
        apb(1'b0, ADDR_PSTAT, 32'h0);
        `CHK(rd[3:2], 2'b01)
        // short-only mode: high period only, raw high-rate moments
        apb(1'b1, ADDR_CTRL, 32'h01);
        for (int t = 0; t < 3; t++)
        begin
            waitTrig(g);
            `CHK(trigLow, 1'b0)
            if (t > 0)
                `CHK(g, 2)
        end
        @(posedge clk_sys);
        mom(mo);
        `CHK(ray.velocity, mo.thetaHigh)
        `CHK(ray.width, mo.widthHigh)
        `CHK(ray.velRef, 1'b0)
        give_verdict();
    end
endmodule // tb_top
